// *** logic/eax_dev_end.sv ***
// Purpose: Endpoint-zero core with automatic descriptor transfers.
// Assumes: Descriptor memory answers in the same cycle as the address.
// Notes: Setup byte 0 is byte 0 of h_setup_data (bits 7:0).
`timescale 1ns/1ps
`include "eax_consts.svh"

// Operation
// - Pointer is two bytes, high and low
// - Low-byte write starts transfer; high alone doesn't
// - Request length from setup bytes 6,7
// - Read descriptor header for its real length
// - Send lesser of requested and actual length
// - Stream memory at pointer through IN path
// - Long data splits into successive IN packets
// - Failed automatic packet is resent without firmware
// - Status stage acknowledged after last packet
// - Firmware uses pointer only with valid length
// - Manual transfers through IN buffer remain possible
// - Short buffer plus byte count behaves alike
// - Device descriptor read is 80/06/01
// - Config read type 02, low value selects
// - String read: index in value, language
// - Firmware picks table from setup byte 2
// - Descriptor write is 00/07, type 01-03
// - Firmware clears hold bit, reads OUT buffer
// - Count OUT bytes against setup length
// - Length reached: status answered automatically
// - Setup stored in setup memory, irq raised
// - Interrupt requests stay active during automation
// - Firmware loads pointer and clears hold bit
module eax_dev_end (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic sys_rst,
  // Link to the host controller
  eax_link_if.dev link,
  // Firmware register port
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // Descriptor memory
  output logic [15:0] mem_addr,
  input wire logic [7:0] mem_rdata,
  // Interrupt requests, one-cycle pulses
  output logic setup_data_valid_irq,
  output logic ep0_in_done_irq
);

  eax_pkg::eax_dev_st_t st;
  logic [7:0] setup_packet_ram [8];
  logic [7:0] ep0_in_buffer [64];
  logic [7:0] ep0_out_buffer [64];
  logic [7:0] setup_pointer_low_byte, setup_pointer_high_byte;
  logic handshake_hold_bit, in_armed;
  logic [6:0] ep0_in_byte_count, pkt_len, send_idx;
  logic [15:0] out_total, remaining, offset, hdr_total;
  logic issuing, auto_src, hdr_cap, v1, e1;
  logic [1:0] hdr_idx, hdr_cap_idx;
  logic [7:0] hdr_len, hdr_type, inbuf_q;

  // Register decode
  wire win_reg = reg_addr[7:6] == `EAX_WIN_REG;
  wire win_in = reg_addr[7:6] == `EAX_WIN_IN;
  wire win_out = reg_addr[7:6] == `EAX_WIN_OUT;
  wire [5:0] roff = reg_addr[5:0];
  wire wr_ptr_lo = reg_wr && win_reg && roff == `EAX_REG_PTR_LO;
  wire wr_ptr_hi = reg_wr && win_reg && roff == `EAX_REG_PTR_HI;
  wire wr_cs = reg_wr && win_reg && roff == `EAX_REG_CS;
  wire wr_in_bc = reg_wr && win_reg && roff == `EAX_REG_IN_BC;
  wire wr_inbuf = reg_wr && win_in;
  wire rd_setup = win_reg && roff >= `EAX_REG_SETUP_BASE && roff <= `EAX_REG_SETUP_LAST;

  wire [15:0] setup_data_pointer = {setup_pointer_high_byte, setup_pointer_low_byte};
  wire [15:0] req_len = {setup_packet_ram[`EAX_SU_LEN_HI],
                         setup_packet_ram[`EAX_SU_LEN_LO]};
  wire su_dir_in = setup_packet_ram[`EAX_SU_TYPE][`EAX_SU_DIR_BIT];

  // Descriptor length: configuration carries a total, others their own length
  wire [15:0] desc_len = (hdr_type == `EAX_DT_CONFIG) ? hdr_total : {8'h00, hdr_len};
  wire [15:0] xfer_len = (req_len < desc_len) ? req_len : desc_len;
  wire [6:0] auto_pkt = (remaining > `EAX_PKT_MAX16) ? `EAX_PKT_MAX : remaining[6:0];
  wire last_iss = send_idx == pkt_len - 7'h01;
  wire auto_idle = st == eax_pkg::EAX_ST_IDLE;
  wire in_now = link.h_in_req && st == eax_pkg::EAX_ST_READY;
  wire man_now = link.h_in_req && auto_idle && in_armed;
  wire start_pkt = in_now || man_now;
  wire [6:0] start_len = in_now ? auto_pkt : ep0_in_byte_count;
  wire data_over = (st == eax_pkg::EAX_ST_DONE)
                || (st == eax_pkg::EAX_ST_READY && remaining == 16'h0000);
  wire out_over = !su_dir_in && out_total >= req_len;
  wire status_ok = !handshake_hold_bit && (data_over || (auto_idle && !in_armed
                   && (su_dir_in || out_over)));
  wire ack_done = st == eax_pkg::EAX_ST_WAIT && link.h_in_ack;
  wire [15:0] next_mem_addr = (st == eax_pkg::EAX_ST_HDR)
                            ? setup_data_pointer + {14'h0000, hdr_idx}
                            : setup_data_pointer + offset + {9'h000, send_idx};

  // Read data mux
  logic [7:0] next_rdata;
  always_comb begin
    next_rdata = 8'h00;
    if (win_in) begin
      next_rdata = ep0_in_buffer[roff];
    end else if (win_out) begin
      next_rdata = ep0_out_buffer[roff];
    end else if (rd_setup) begin
      next_rdata = setup_packet_ram[roff[2:0]];
    end else if (win_reg) begin
      unique case (roff)
        `EAX_REG_PTR_LO: next_rdata = setup_pointer_low_byte;
        `EAX_REG_PTR_HI: next_rdata = setup_pointer_high_byte;
        `EAX_REG_CS: next_rdata = {5'h00, in_armed, !auto_idle, handshake_hold_bit};
        `EAX_REG_IN_BC: next_rdata = {1'b0, ep0_in_byte_count};
        `EAX_REG_OUT_CNT_LO: next_rdata = out_total[7:0];
        `EAX_REG_OUT_CNT_HI: next_rdata = out_total[15:8];
        default: next_rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    reg_rdata <= reg_rd ? next_rdata : 8'h00;
    if (wr_inbuf) ep0_in_buffer[roff] <= reg_wdata;
    if (link.h_out_valid) ep0_out_buffer[out_total[5:0]] <= link.h_out_byte;
    if (link.h_setup) begin
      for (int i = 0; i < 8; i++) begin
        setup_packet_ram[i] <= link.h_setup_data[8 * i +: 8];
      end
    end
    inbuf_q <= ep0_in_buffer[send_idx[5:0]];
    if (hdr_cap) begin
      unique case (hdr_cap_idx)
        2'h0: hdr_len <= mem_rdata;
        2'h1: hdr_type <= mem_rdata;
        2'h2: hdr_total[7:0] <= mem_rdata;
        2'h3: hdr_total[15:8] <= mem_rdata;
      endcase
    end
    mem_addr <= next_mem_addr;
  end

  // Firmware registers; a setup packet wins over a firmware clear
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      setup_pointer_low_byte <= 8'h00;
      setup_pointer_high_byte <= 8'h00;
      handshake_hold_bit <= 1'b0;
      ep0_in_byte_count <= 7'h00;
      in_armed <= 1'b0;
      out_total <= 16'h0000;
    end else begin
      if (wr_ptr_lo) setup_pointer_low_byte <= reg_wdata;
      if (wr_ptr_hi) setup_pointer_high_byte <= reg_wdata;
      if (wr_cs && reg_wdata[`EAX_CS_HANDSHAKE_HOLD_BIT]) handshake_hold_bit <= 1'b0;
      if (link.h_out_valid) out_total <= out_total + 16'h0001;
      if (man_now) in_armed <= 1'b0;
      if (wr_in_bc) begin
        ep0_in_byte_count <= reg_wdata[6:0];
        in_armed <= 1'b1;
      end
      if (link.h_setup) begin
        handshake_hold_bit <= 1'b1;
        in_armed <= 1'b0;
        out_total <= 16'h0000;
      end
    end
  end

  // Automatic data stage
  always_ff @(posedge ref_clk) begin
    if (sys_rst || link.h_setup) begin
      st <= eax_pkg::EAX_ST_IDLE;
      remaining <= 16'h0000;
      offset <= 16'h0000;
      pkt_len <= 7'h00;
      send_idx <= 7'h00;
      issuing <= 1'b0;
      auto_src <= 1'b0;
      hdr_idx <= 2'h0;
    end else begin
      unique case (st)
        eax_pkg::EAX_ST_IDLE: begin
          if (wr_ptr_lo) begin
            st <= eax_pkg::EAX_ST_HDR;
            hdr_idx <= 2'h0;
          end
        end
        eax_pkg::EAX_ST_HDR: begin
          hdr_idx <= hdr_idx + 2'h1;
          if (hdr_idx == `EAX_HDR_LAST) st <= eax_pkg::EAX_ST_CALC;
        end
        eax_pkg::EAX_ST_CALC: begin
          if (!hdr_cap) begin
            remaining <= xfer_len;
            offset <= 16'h0000;
            st <= eax_pkg::EAX_ST_READY;
          end
        end
        eax_pkg::EAX_ST_READY: begin
        end
        eax_pkg::EAX_ST_SEND: begin
          send_idx <= send_idx + 7'h01;
          if (last_iss) begin
            issuing <= 1'b0;
            st <= eax_pkg::EAX_ST_WAIT;
          end
        end
        eax_pkg::EAX_ST_WAIT: begin
          if (link.h_in_ack && auto_src) begin
            offset <= offset + {9'h000, pkt_len};
            remaining <= remaining - {9'h000, pkt_len};
            st <= (remaining == {9'h000, pkt_len} && pkt_len != `EAX_PKT_MAX)
                ? eax_pkg::EAX_ST_DONE : eax_pkg::EAX_ST_READY;
          end else if (link.h_in_ack) begin
            st <= eax_pkg::EAX_ST_IDLE;
          end else if (link.h_in_err) begin
            st <= auto_src ? eax_pkg::EAX_ST_READY : eax_pkg::EAX_ST_IDLE;
          end
        end
        eax_pkg::EAX_ST_DONE: if (link.h_status_req) st <= eax_pkg::EAX_ST_IDLE;
      endcase
      if (st == eax_pkg::EAX_ST_READY && link.h_status_req && remaining == 16'h0000) begin
        st <= eax_pkg::EAX_ST_IDLE;
      end
      if (start_pkt) begin
        pkt_len <= start_len;
        send_idx <= 7'h00;
        auto_src <= in_now;
        issuing <= start_len != 7'h00;
        st <= (start_len != 7'h00) ? eax_pkg::EAX_ST_SEND : eax_pkg::EAX_ST_WAIT;
      end
    end
  end

  // Pipeline and link outputs
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      hdr_cap <= 1'b0;
      hdr_cap_idx <= 2'h0;
      v1 <= 1'b0;
      e1 <= 1'b0;
      link.d_in_valid <= 1'b0;
      link.d_in_byte <= 8'h00;
      link.d_in_end <= 1'b0;
      link.d_in_nak <= 1'b0;
      link.d_status_ack <= 1'b0;
      link.d_status_nak <= 1'b0;
      setup_data_valid_irq <= 1'b0;
      ep0_in_done_irq <= 1'b0;
    end else begin
      hdr_cap <= st == eax_pkg::EAX_ST_HDR && !link.h_setup;
      hdr_cap_idx <= hdr_idx;
      v1 <= st == eax_pkg::EAX_ST_SEND && issuing && !link.h_setup;
      e1 <= (st == eax_pkg::EAX_ST_SEND && issuing && last_iss && !link.h_setup)
         || (start_pkt && start_len == 7'h00);
      link.d_in_valid <= v1;
      link.d_in_byte <= auto_src ? mem_rdata : inbuf_q;
      link.d_in_end <= e1;
      link.d_in_nak <= link.h_in_req && !start_pkt;
      link.d_status_ack <= link.h_status_req && status_ok;
      link.d_status_nak <= link.h_status_req && !status_ok;
      setup_data_valid_irq <= link.h_setup;
      ep0_in_done_irq <= ack_done;
    end
  end

endmodule : eax_dev_end

// *** logic/eax_consts.svh ***
// Purpose: Shared constants of the endpoint-zero descriptor assist.
// Assumes: Firmware register port with 8-bit address and data.
// Notes: Addresses 0x40-0x7f map the IN buffer, 0x80-0xbf the OUT buffer.
`ifndef EAX_CONSTS_SVH
`define EAX_CONSTS_SVH

// Address windows, selected by address bits 7:6
`define EAX_WIN_REG 2'h0
`define EAX_WIN_IN 2'h1
`define EAX_WIN_OUT 2'h2
// Registers in the register window, address bits 5:0
`define EAX_REG_PTR_LO 6'h00
`define EAX_REG_PTR_HI 6'h01
`define EAX_REG_CS 6'h02
`define EAX_REG_IN_BC 6'h03
`define EAX_REG_OUT_CNT_LO 6'h04
`define EAX_REG_OUT_CNT_HI 6'h05
`define EAX_REG_SETUP_BASE 6'h08
`define EAX_REG_SETUP_LAST 6'h0f
// Control and status bit positions
`define EAX_CS_HANDSHAKE_HOLD_BIT 0
`define EAX_CS_AUTO_BUSY 1
`define EAX_CS_IN_ARMED 2
// Setup packet byte positions
`define EAX_SU_TYPE 3'h0
`define EAX_SU_REQ 3'h1
`define EAX_SU_VAL_LO 3'h2
`define EAX_SU_VAL_HI 3'h3
`define EAX_SU_IDX_LO 3'h4
`define EAX_SU_IDX_HI 3'h5
`define EAX_SU_LEN_LO 3'h6
`define EAX_SU_LEN_HI 3'h7
`define EAX_SU_DIR_BIT 7
// Request encodings
`define EAX_RT_IN_DEV 8'h80
`define EAX_RT_OUT_DEV 8'h00
`define EAX_REQ_GET_DESC 8'h06
`define EAX_REQ_SET_DESC 8'h07
`define EAX_DT_DEVICE 8'h01
`define EAX_DT_CONFIG 8'h02
`define EAX_DT_STRING 8'h03
// Descriptor header: bytes read before any data
`define EAX_HDR_LAST 2'h3
// Largest endpoint-zero packet
`define EAX_PKT_MAX 7'h40
`define EAX_PKT_MAX16 16'h0040

`endif

// *** logic/eax_pkg.sv ***
// Purpose: Types of the endpoint-zero descriptor assist.
// Assumes: Constants come from eax_consts.svh.
// Notes: States carry no explicit codes; they count up from 0 in listed order.
package eax_pkg;

  typedef enum logic [2:0] {
    EAX_ST_IDLE,
    EAX_ST_HDR,
    EAX_ST_CALC,
    EAX_ST_READY,
    EAX_ST_SEND,
    EAX_ST_WAIT,
    EAX_ST_DONE
  } eax_dev_st_t;

  typedef enum logic [1:0] {
    EAX_H_IDLE,
    EAX_H_IN,
    EAX_H_STAT
  } eax_host_st_t;

  typedef enum logic [1:0] {
    EAX_RQ_GET_DEVICE,
    EAX_RQ_GET_CONFIG,
    EAX_RQ_GET_STRING,
    EAX_RQ_SET_DESC
  } eax_req_t;

endpackage : eax_pkg

// *** logic/eax_link_if.sv ***
// Purpose: Transaction link between host controller and device core.
// Assumes: Both ends on ref_clk; every h_ and d_ strobe is one cycle.
// Notes: d_in_end marks the last byte, or alone an empty packet.
`timescale 1ns/1ps
interface eax_link_if;
  // Host to device
  logic h_setup;
  logic [63:0] h_setup_data;
  logic h_in_req;
  logic h_in_ack;
  logic h_in_err;
  logic h_out_valid;
  logic [7:0] h_out_byte;
  logic h_status_req;
  // Device to host
  logic d_in_valid;
  logic [7:0] d_in_byte;
  logic d_in_end;
  logic d_in_nak;
  logic d_status_ack;
  logic d_status_nak;

  modport dev (
    input h_setup, h_setup_data, h_in_req, h_in_ack, h_in_err,
    input h_out_valid, h_out_byte, h_status_req,
    output d_in_valid, d_in_byte, d_in_end, d_in_nak, d_status_ack, d_status_nak
  );

  modport host (
    output h_setup, h_setup_data, h_in_req, h_in_ack, h_in_err,
    output h_out_valid, h_out_byte, h_status_req,
    input d_in_valid, d_in_byte, d_in_end, d_in_nak, d_status_ack, d_status_nak
  );
endinterface : eax_link_if

// *** logic/eax_host_end.sv ***
// Purpose: Host-controller end issuing endpoint-zero control transfers.
// Assumes: Device end on the same ref_clk; no synchronisers needed.
// Notes: One outstanding transaction at a time; requests while busy drop.
`timescale 1ns/1ps
`include "eax_consts.svh"

module eax_host_end (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic sys_rst,
  // Link to the device
  eax_link_if.host link,
  // Setup request
  input wire logic usr_setup_go,
  input wire eax_pkg::eax_req_t usr_req,
  input wire logic [7:0] usr_value_lo,
  input wire logic [7:0] usr_set_type,
  input wire logic [15:0] usr_index,
  input wire logic [15:0] usr_length,
  // Data and status stages
  input wire logic usr_in_go,
  input wire logic usr_in_fail,
  input wire logic usr_out_go,
  input wire logic [7:0] usr_out_byte,
  input wire logic usr_status_go,
  // Results
  output logic usr_in_valid,
  output logic [7:0] usr_in_byte,
  output logic usr_in_done,
  output logic usr_in_nak,
  output logic [6:0] usr_in_count,
  output logic usr_status_done,
  output logic usr_status_acked,
  output logic usr_busy
);

  eax_pkg::eax_host_st_t st;
  logic fail_q;
  logic [6:0] cnt;

  // Setup fields per request kind
  wire is_set = usr_req == eax_pkg::EAX_RQ_SET_DESC;
  wire [7:0] su_type = is_set ? `EAX_RT_OUT_DEV : `EAX_RT_IN_DEV;
  wire [7:0] su_req = is_set ? `EAX_REQ_SET_DESC : `EAX_REQ_GET_DESC;
  wire [7:0] su_vhi = (usr_req == eax_pkg::EAX_RQ_GET_DEVICE) ? `EAX_DT_DEVICE
                    : (usr_req == eax_pkg::EAX_RQ_GET_CONFIG) ? `EAX_DT_CONFIG
                    : (usr_req == eax_pkg::EAX_RQ_GET_STRING) ? `EAX_DT_STRING
                    : usr_set_type;
  wire [15:0] su_idx = (usr_req == eax_pkg::EAX_RQ_GET_STRING) ? usr_index : 16'h0000;
  // Length always in bytes 6-7 so the pointer sequence stays usable
  wire [63:0] su_word = {usr_length, su_idx, su_vhi, usr_value_lo, su_req, su_type};
  wire idle = st == eax_pkg::EAX_H_IDLE;

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      st <= eax_pkg::EAX_H_IDLE;
      fail_q <= 1'b0;
      cnt <= 7'h00;
      link.h_setup <= 1'b0;
      link.h_setup_data <= 64'h0000000000000000;
      link.h_in_req <= 1'b0;
      link.h_in_ack <= 1'b0;
      link.h_in_err <= 1'b0;
      link.h_out_valid <= 1'b0;
      link.h_out_byte <= 8'h00;
      link.h_status_req <= 1'b0;
      usr_in_valid <= 1'b0;
      usr_in_byte <= 8'h00;
      usr_in_done <= 1'b0;
      usr_in_nak <= 1'b0;
      usr_in_count <= 7'h00;
      usr_status_done <= 1'b0;
      usr_status_acked <= 1'b0;
      usr_busy <= 1'b0;
    end else begin
      link.h_setup <= idle && usr_setup_go;
      if (idle && usr_setup_go) link.h_setup_data <= su_word;
      link.h_in_req <= idle && usr_in_go;
      link.h_out_valid <= idle && usr_out_go;
      link.h_out_byte <= usr_out_byte;
      link.h_status_req <= idle && usr_status_go;
      link.h_in_ack <= 1'b0;
      link.h_in_err <= 1'b0;
      usr_in_valid <= 1'b0;
      usr_in_done <= 1'b0;
      usr_in_nak <= 1'b0;
      usr_status_done <= 1'b0;
      unique case (st)
        eax_pkg::EAX_H_IDLE: begin
          if (usr_in_go) begin
            st <= eax_pkg::EAX_H_IN;
            fail_q <= usr_in_fail;
            cnt <= 7'h00;
          end else if (usr_status_go) begin
            st <= eax_pkg::EAX_H_STAT;
          end
        end
        eax_pkg::EAX_H_IN: begin
          if (link.d_in_valid) begin
            usr_in_valid <= 1'b1;
            usr_in_byte <= link.d_in_byte;
            cnt <= cnt + 7'h01;
          end
          if (link.d_in_end) begin
            link.h_in_ack <= !fail_q;
            link.h_in_err <= fail_q;
            usr_in_done <= 1'b1;
            usr_in_count <= cnt + {6'h00, link.d_in_valid};
            st <= eax_pkg::EAX_H_IDLE;
          end else if (link.d_in_nak) begin
            usr_in_done <= 1'b1;
            usr_in_nak <= 1'b1;
            usr_in_count <= 7'h00;
            st <= eax_pkg::EAX_H_IDLE;
          end
        end
        eax_pkg::EAX_H_STAT: begin
          if (link.d_status_ack || link.d_status_nak) begin
            usr_status_done <= 1'b1;
            usr_status_acked <= link.d_status_ack;
            st <= eax_pkg::EAX_H_IDLE;
          end
        end
        default: st <= eax_pkg::EAX_H_IDLE;
      endcase
      usr_busy <= !(idle && !usr_in_go && !usr_status_go)
               && !(st != eax_pkg::EAX_H_IDLE && (link.d_in_end || link.d_in_nak
                    || link.d_status_ack || link.d_status_nak));
    end
  end

endmodule : eax_host_end

// *** tb/eax_link_monitor.sv ***
// Purpose: Timing checks on the endpoint-zero link.
// Assumes: One clock; sys_rst synchronous, active high.
// Notes: Firmware port is judged by the bench.
`timescale 1ns/1ps
module eax_link_monitor (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic sys_rst,
  // Host side
  input wire logic h_setup,
  input wire logic [63:0] h_setup_data,
  input wire logic h_in_req,
  input wire logic h_out_valid,
  input wire logic h_status_req,
  // Device side
  input wire logic d_in_valid,
  input wire logic d_in_end,
  input wire logic d_in_nak,
  input wire logic d_status_ack,
  input wire logic d_status_nak
);
  logic [6:0] pkt_cnt;
  logic [15:0] out_cnt;
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (sys_rst);
  // A new setup aborts any packet
  always_ff @(posedge ref_clk) begin
    if (sys_rst || h_setup || d_in_end) begin
      pkt_cnt <= 7'h00;
    end else if (d_in_valid) begin
      pkt_cnt <= pkt_cnt + 7'h01;
    end
  end
  always_ff @(posedge ref_clk) begin
    if (sys_rst || h_setup) begin
      out_cnt <= 16'h0000;
    end else if (h_out_valid) begin
      out_cnt <= out_cnt + 16'h0001;
    end
  end
  sequence token_taken;
    h_in_req ##1 !d_in_nak;
  endsequence
  sequence first_data;
    (##1 (d_in_end && !d_in_valid)) or (##2 d_in_valid);
  endsequence
  chk_status_answer: assert property (h_status_req |=> d_status_ack != d_status_nak)
    else $error("status token not answered");
  chk_status_cause: assert property ((d_status_ack || d_status_nak) |-> $past(h_status_req))
    else $error("status answer without token");
  chk_first_byte: assert property (token_taken |-> first_data)
    else $error("IN data late or early");
  chk_nak_cause: assert property (d_in_nak |-> $past(h_in_req) && !d_in_valid)
    else $error("nak without token");
  chk_byte_stream: assert property (d_in_valid && !d_in_end |=> d_in_valid)
    else $error("gap inside packet");
  chk_end_gap: assert property (d_in_end |=> !d_in_valid [*3])
    else $error("data right after packet end");
  chk_packet_size: assert property (d_in_valid |-> pkt_cnt < 7'h40)
    else $error("packet above 64 bytes");
  chk_out_length: assert property (d_status_ack && !h_setup_data[7]
    |-> out_cnt >= h_setup_data[63:48])
    else $error("status acked before all OUT bytes");
endmodule : eax_link_monitor

// *** tb/tb_top.sv ***
// Purpose: Self-checking bench joining host end and device end.
// Assumes: Descriptor memory is a combinational table.
// Notes: Host end acks or fails each IN packet itself.
`timescale 1ns/1ps
module tb_top;
  localparam logic [63:0] SU_DEV = 64'h00ff_0000_0100_0680;
  logic ref_clk, sys_rst, reg_wr, reg_rd, setup_data_valid_irq, ep0_in_done_irq;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, mem_rdata, usr_value_lo, usr_set_type;
  logic [7:0] usr_out_byte, usr_in_byte;
  logic usr_setup_go, usr_in_go, usr_in_fail, usr_out_go, usr_status_go, usr_in_valid;
  logic usr_in_done, usr_in_nak, usr_status_done, usr_status_acked, usr_busy, last_nak;
  logic [15:0] mem_addr, usr_index, usr_length;
  logic [6:0] usr_in_count;
  logic [7:0] mem [0:255];
  logic [7:0] rx_q [$];
  eax_pkg::eax_req_t usr_req;
  int err_count, samples_checked, irq_n, done_n, stat_n;
  eax_link_if link ();
  // Table mirrored every 256 bytes
  assign mem_rdata = mem[mem_addr[7:0]];
  eax_dev_end i_eax_dev_end (.ref_clk(ref_clk), .sys_rst(sys_rst), .link(link),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .mem_addr(mem_addr), .mem_rdata(mem_rdata),
    .setup_data_valid_irq(setup_data_valid_irq), .ep0_in_done_irq(ep0_in_done_irq));
  eax_host_end i_eax_host_end (.ref_clk(ref_clk), .sys_rst(sys_rst), .link(link),
    .usr_setup_go(usr_setup_go), .usr_req(usr_req), .usr_value_lo(usr_value_lo),
    .usr_set_type(usr_set_type), .usr_index(usr_index), .usr_length(usr_length),
    .usr_in_go(usr_in_go), .usr_in_fail(usr_in_fail), .usr_out_go(usr_out_go),
    .usr_out_byte(usr_out_byte), .usr_status_go(usr_status_go),
    .usr_in_valid(usr_in_valid), .usr_in_byte(usr_in_byte), .usr_in_done(usr_in_done),
    .usr_in_nak(usr_in_nak), .usr_in_count(usr_in_count),
    .usr_status_done(usr_status_done), .usr_status_acked(usr_status_acked),
    .usr_busy(usr_busy));
  eax_link_monitor i_eax_link_monitor (.ref_clk(ref_clk), .sys_rst(sys_rst),
    .h_setup(link.h_setup), .h_setup_data(link.h_setup_data), .h_in_req(link.h_in_req),
    .h_out_valid(link.h_out_valid), .h_status_req(link.h_status_req),
    .d_in_valid(link.d_in_valid), .d_in_end(link.d_in_end), .d_in_nak(link.d_in_nak),
    .d_status_ack(link.d_status_ack), .d_status_nak(link.d_status_nak));
  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) begin
    if (usr_in_valid) rx_q.push_back(usr_in_byte);
    if (usr_in_done) last_nak <= usr_in_nak;
    if (setup_data_valid_irq) irq_n++;
    if (ep0_in_done_irq) done_n++;
    if (usr_status_done) stat_n++;
  end
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_count++;
      $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic wrap_up;
    $display("checks=%0d mismatches=%0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : wrap_up
  task automatic wait_idle;
    int n;
    n = 0;
    do begin
      @(posedge ref_clk);
      #1;
      n++;
    end while (usr_busy !== 1'b0 && n < 300);
    if (usr_busy !== 1'b0) err_count++;
    // Done pulse lands as busy drops; bench logs it a cycle later
    repeat (2) @(posedge ref_clk);
    #1;
  endtask : wait_idle
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rdc(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1;
    check(16'(reg_rdata & m), 16'(e));
  endtask : rdc
  task automatic setup(input eax_pkg::eax_req_t rq, input logic [7:0] st,
                       input logic [15:0] len);
    @(posedge ref_clk);
    usr_req <= rq;
    usr_set_type <= st;
    usr_value_lo <= st;
    usr_index <= {st, st};
    usr_length <= len;
    usr_setup_go <= 1'b1;
    @(posedge ref_clk);
    usr_setup_go <= 1'b0;
    wait_idle();
  endtask : setup
  task automatic point(input logic [7:0] lo);
    wr(8'h02, 8'h01);
    wr(8'h01, 8'h00);
    rdc(8'h02, 8'h02, 8'h00);
    wr(8'h00, lo);
    // Header read needs at least 6 cycles
    repeat (10) @(posedge ref_clk);
    rdc(8'h02, 8'h02, 8'h02);
  endtask : point
  task automatic in_pkt(input logic fail, input logic nak, input int n, input int base);
    rx_q.delete();
    @(posedge ref_clk);
    usr_in_fail <= fail;
    usr_in_go <= 1'b1;
    @(posedge ref_clk);
    usr_in_go <= 1'b0;
    wait_idle();
    check(16'(last_nak), 16'(nak));
    check(16'(rx_q.size()), 16'(n));
    if (!nak) check(16'(usr_in_count), 16'(n));
    for (int k = 0; k < n && k < rx_q.size(); k++) check(16'(rx_q[k]), 16'(mem[base + k]));
  endtask : in_pkt
  task automatic send_out(input logic [7:0] b);
    @(posedge ref_clk);
    usr_out_byte <= b;
    usr_out_go <= 1'b1;
    @(posedge ref_clk);
    usr_out_go <= 1'b0;
    wait_idle();
  endtask : send_out
  task automatic status(input logic ack);
    @(posedge ref_clk);
    usr_status_go <= 1'b1;
    @(posedge ref_clk);
    usr_status_go <= 1'b0;
    wait_idle();
    check(16'(usr_status_acked), 16'(ack));
  endtask : status
  initial begin
    sys_rst = 1'b1;
    {reg_wr, reg_rd, usr_setup_go, usr_in_go, usr_in_fail, usr_out_go, usr_status_go} = '0;
    {reg_addr, reg_wdata, usr_value_lo, usr_set_type, usr_out_byte} = '0;
    {usr_index, usr_length} = '0;
    usr_req = eax_pkg::EAX_RQ_GET_DEVICE;
    for (int i = 0; i < 256; i++) mem[i] = 8'(i) ^ 8'h5a;
    // 91-byte device table, 70-byte configuration table
    {mem[8'h10], mem[8'h11]} = 16'h5b01;
    {mem[8'h80], mem[8'h81], mem[8'h82], mem[8'h83]} = 32'h0902_4600;
    repeat (20) @(posedge ref_clk);
    sys_rst <= 1'b0;
    rdc(8'h02, 8'hff, 8'h00);
    rdc(8'h06, 8'hff, 8'h00);
    $display("reset test done");
    setup(eax_pkg::EAX_RQ_GET_DEVICE, 8'h00, 16'h00ff);
    for (int i = 0; i < 8; i++) rdc(8'h08 + 8'(i), 8'hff, SU_DEV[8*i +: 8]);
    in_pkt(1'b0, 1'b1, 0, 0);
    point(8'h10);
    in_pkt(1'b1, 1'b0, 64, 16);
    in_pkt(1'b0, 1'b0, 64, 16);
    in_pkt(1'b0, 1'b0, 27, 80);
    status(1'b1);
    $display("device read test done");
    setup(eax_pkg::EAX_RQ_GET_CONFIG, 8'h01, 16'h0100);
    rdc(8'h0a, 8'hff, 8'h01);
    point(8'h80);
    in_pkt(1'b0, 1'b0, 64, 128);
    in_pkt(1'b0, 1'b0, 6, 192);
    status(1'b1);
    setup(eax_pkg::EAX_RQ_GET_STRING, 8'h02, 16'h0005);
    rdc(8'h0c, 8'hff, 8'h02);
    point(8'h10);
    in_pkt(1'b0, 1'b0, 5, 16);
    status(1'b1);
    $display("config and string test done");
    setup(eax_pkg::EAX_RQ_GET_DEVICE, 8'h00, 16'h0003);
    wr(8'h02, 8'h01);
    for (int i = 0; i < 3; i++) wr(8'h40 + 8'(i), mem[8'h20 + i]);
    wr(8'h03, 8'h03);
    rdc(8'h02, 8'h04, 8'h04);
    rdc(8'h03, 8'hff, 8'h03);
    in_pkt(1'b0, 1'b0, 3, 32);
    status(1'b1);
    $display("manual test done");
    for (int t = 1; t < 4; t++) begin
      setup(eax_pkg::EAX_RQ_SET_DESC, 8'(t), 16'(t));
      rdc(8'h09, 8'hff, 8'h07);
      rdc(8'h0b, 8'hff, 8'(t));
      wr(8'h02, 8'h01);
      for (int j = 1; j < t; j++) send_out(8'(j));
      status(1'b0);
      send_out(8'h3c);
      status(1'b1);
      rdc(8'h04, 8'hff, 8'(t));
      rdc(8'h05, 8'hff, 8'h00);
      rdc(8'h80 + 8'(t) - 8'h01, 8'hff, 8'h3c);
    end
    $display("descriptor write test done");
    check(16'(irq_n), 16'h0007);
    check(16'(done_n), 16'h0006);
    check(16'(stat_n), 16'h000a);
    wrap_up();
  end
  // About 600 cycles expected
  initial begin
    repeat (30000) @(posedge ref_clk);
    err_count++;
    wrap_up();
  end
endmodule : tb_top
